// ---- pkg/bhcd_consts.vh ----
// constants for the hall commutation decoder
`ifndef BHCD_CONSTS_VH
`define BHCD_CONSTS_VH
`define BHCD_REF_WIDTH 8
`define BHCD_CARRIER_TIME_NS 50000
`define BHCD_CLOCK_PERIOD_NS 25
`define BHCD_CARRIER_CYCLES (`BHCD_CARRIER_TIME_NS / `BHCD_CLOCK_PERIOD_NS)
`define BHCD_SPEED_OFF_DEFAULT 8'h20
`define BHCD_LIMIT_DELAY_NS 1000
`define BHCD_LIMIT_DELAY_CYCLES (`BHCD_LIMIT_DELAY_NS / `BHCD_CLOCK_PERIOD_NS)
`define BHCD_LIMIT_CNT_WIDTH 8
`define BHCD_STATE_IDLE 2'h0
`define BHCD_STATE_RUN 2'h1
`define BHCD_STATE_LIMIT 2'h2
`endif

// ---- src/bhcd_carrier.v ----
// triangular carrier counter with rate set by two external parts
`timescale 1ns/100ps
module bhcd_carrier #(
   parameter WIDTH = 8
) (
   clock,
   rst,
   stepSize,
   carrier
);
   input wire clock;
   input wire rst;
   input wire [WIDTH-1:0] stepSize;
   output reg [WIDTH-1:0] carrier;

   reg goingUp_reg;
   wire [WIDTH:0] upSum;
   wire [WIDTH:0] downDiff;
   localparam [WIDTH:0] TOP = {1'b0, {WIDTH{1'b1}}};

   assign upSum = {1'b0, carrier} + {1'b0, stepSize};
   assign downDiff = {1'b0, carrier} - {1'b0, stepSize};

   // step of zero freezes the ramp; the decoder adds one so it never sends zero
   always @(posedge clock) begin
      if (rst) begin
         carrier <= {WIDTH{1'b0}};
         goingUp_reg <= 1'b1;
      end else if (goingUp_reg) begin
         if (upSum >= TOP) begin
            carrier <= TOP[WIDTH-1:0];
            goingUp_reg <= 1'b0;
         end else begin
            carrier <= upSum[WIDTH-1:0];
         end
      end else begin
         if (downDiff[WIDTH] || downDiff == {(WIDTH+1){1'b0}}) begin
            carrier <= {WIDTH{1'b0}};
            goingUp_reg <= 1'b1;
         end else begin
            carrier <= downDiff[WIDTH-1:0];
         end
      end
   end
endmodule // bhcd_carrier

// ---- src/bhcd_high_latch.v ----
// one phase high-side latch: set by level-shift pulse, cleared on off or undervoltage
`timescale 1ns/100ps
module bhcd_high_latch (
   clock,
   rst,
   command,
   turnOnPulse,
   bootLow,
   bootRecovered,
   limitOff,
   gateOn
);
   input wire clock;
   input wire rst;
   input wire command;
   input wire turnOnPulse;
   input wire bootLow;
   input wire bootRecovered;
   input wire limitOff;
   output reg gateOn;

   reg lockout_reg;

   always @(posedge clock) begin
      if (rst) begin
         gateOn <= 1'b0;
         lockout_reg <= 1'b0;
      end else begin
         if (bootLow)
            lockout_reg <= 1'b1;
         else if (bootRecovered && turnOnPulse)
            lockout_reg <= 1'b0;
         if (!command || bootLow || limitOff)
            gateOn <= 1'b0;
         else if (turnOnPulse && (!lockout_reg || bootRecovered))
            gateOn <= 1'b1;
      end
   end
endmodule // bhcd_high_latch

// ---- src/bhcd_hall_decoder.v ----
// hall commutation decoder with pwm chopping of the high side
`timescale 1ns/100ps
`include "bhcd_consts.vh"

// What this block does
// - hall input is high when its positive input exceeds its negative input
// - states 101,100,110 drive U low/V high, U low/W high, V low/W high
// - hall 000 or 111 turns every switch off
// - select high: revolution output high when exactly two halls high
// - select low: revolution output follows hall A
// - open select reads as high; only this pin picks pulse count
// - pwm chops only the commanded high side, low side stays on
// - duty from speed reference against carrier; higher reference longer on
// - triangular carrier rate set by external capacitor and resistor
// - high-side turn-on pulse only on hall edge or pwm edge
// - high side stays off until a new turn-on pulse
// - bootstrap undervoltage forces that phase high side off
// - recover only after supply 0.5 V above detect and fresh pulse
// - speed reference below off threshold holds all switches off
// - current over limit turns high side off after delay, next pwm on releases
module bhcd_hall_decoder #(
   parameter REF_WIDTH = `BHCD_REF_WIDTH,
   parameter [REF_WIDTH-1:0] SPEED_OFF = `BHCD_SPEED_OFF_DEFAULT,
   parameter LIMIT_DELAY = `BHCD_LIMIT_DELAY_CYCLES
) (
   clock,
   rst,
   hall_a_pos,
   hall_a_neg,
   hall_b_pos,
   hall_b_neg,
   hall_c_pos,
   hall_c_neg,
   pulse_count_select,
   pulse_count_select_open,
   speed_reference_in,
   carrier_cap_pin,
   carrier_res_pin,
   current_sense_in,
   current_limit_level,
   boot_cap_a,
   boot_cap_b,
   boot_cap_c,
   boot_detect_level,
   boot_recover_level,
   highSideA,
   highSideB,
   highSideC,
   lowSideA,
   lowSideB,
   lowSideC,
   revolution_pulse_out
);
   input wire clock;
   input wire rst;
   input wire [REF_WIDTH-1:0] hall_a_pos;
   input wire [REF_WIDTH-1:0] hall_a_neg;
   input wire [REF_WIDTH-1:0] hall_b_pos;
   input wire [REF_WIDTH-1:0] hall_b_neg;
   input wire [REF_WIDTH-1:0] hall_c_pos;
   input wire [REF_WIDTH-1:0] hall_c_neg;
   input wire pulse_count_select;
   input wire pulse_count_select_open;
   input wire [REF_WIDTH-1:0] speed_reference_in;
   input wire [REF_WIDTH-1:0] carrier_cap_pin;
   input wire [REF_WIDTH-1:0] carrier_res_pin;
   input wire [REF_WIDTH-1:0] current_sense_in;
   input wire [REF_WIDTH-1:0] current_limit_level;
   input wire [REF_WIDTH-1:0] boot_cap_a;
   input wire [REF_WIDTH-1:0] boot_cap_b;
   input wire [REF_WIDTH-1:0] boot_cap_c;
   input wire [REF_WIDTH-1:0] boot_detect_level;
   input wire [REF_WIDTH-1:0] boot_recover_level;
   output wire highSideA;
   output wire highSideB;
   output wire highSideC;
   output reg lowSideA;
   output reg lowSideB;
   output reg lowSideC;
   output reg revolution_pulse_out;

   wire [2:0] hallNow;
   reg [2:0] hall_reg;
   reg [2:0] highCmd;
   reg [2:0] lowCmd;
   reg pwm_reg;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [`BHCD_LIMIT_CNT_WIDTH-1:0] limitCnt_reg;
   reg limitOff_reg;
   reg [`BHCD_LIMIT_CNT_WIDTH-1:0] limitCnt_next;
   reg limitOff_next;
   reg [2:0] lowSide_next;
   reg revolution_next;
   wire [REF_WIDTH-1:0] carrier;
   wire [REF_WIDTH-1:0] stepSize;
   wire pwmNow;
   wire speedOff;
   wire hallEdge;
   wire pwmRise;
   wire pwmEdge;
   wire turnOnPulse;
   wire selectHigh;
   wire [2:0] bootLow;
   wire [2:0] bootOk;
   wire [2:0] gateOn;
   wire overLimit;
   wire limitCut;

   // equal inputs read low: the comparator wants a strict excess
   assign hallNow[2] = hall_a_pos > hall_a_neg;
   assign hallNow[1] = hall_b_pos > hall_b_neg;
   assign hallNow[0] = hall_c_pos > hall_c_neg;

   // rate grows with smaller cap and resistor, as the analog ramp does
   assign stepSize = (~carrier_cap_pin >> 4) + (~carrier_res_pin >> 4) + 8'h01;

   // carrier period follows the step: longer with larger cap or resistor values
   bhcd_carrier #(
      .WIDTH(REF_WIDTH)
   ) carrierGen (
      .clock(clock),
      .rst(rst),
      .stepSize(stepSize),
      .carrier(carrier)
   );

   assign pwmNow = speed_reference_in > carrier;
   assign speedOff = speed_reference_in < SPEED_OFF;
   assign selectHigh = pulse_count_select | pulse_count_select_open;
   // every phase sees the same pulse; only the commanded latch turns on, and any recovered latch clears its lockout on it
   assign hallEdge = hall_reg != hallNow;
   assign pwmRise = pwmNow & ~pwm_reg;
   assign pwmEdge = pwmNow != pwm_reg;
   assign turnOnPulse = hallEdge | pwmEdge;
   assign overLimit = current_sense_in > current_limit_level;
   // the pwm on edge both lifts the cut and is the turn-on pulse, so it must win here
   assign limitCut = limitOff_reg & ~pwmRise;

   // decoded commutation table
   always @* begin
      highCmd = 3'h0;
      lowCmd = 3'h0;
      case (hallNow)
         3'h5: begin
            lowCmd = 3'h4;
            highCmd = 3'h2;
         end
         3'h4: begin
            lowCmd = 3'h4;
            highCmd = 3'h1;
         end
         3'h6: begin
            lowCmd = 3'h2;
            highCmd = 3'h1;
         end
         3'h2: begin
            highCmd = 3'h4;
            lowCmd = 3'h2;
         end
         3'h3: begin
            highCmd = 3'h4;
            lowCmd = 3'h1;
         end
         3'h1: begin
            highCmd = 3'h2;
            lowCmd = 3'h1;
         end
         default: begin
            // 000 and 111 are not valid rotor positions
            highCmd = 3'h0;
            lowCmd = 3'h0;
         end
      endcase
   end

   // current limit: idle, waiting the delay in run, then latched off
   always @* begin
      state_next = state_reg;
      case (state_reg)
         `BHCD_STATE_IDLE: begin
            if (overLimit)
               state_next = `BHCD_STATE_RUN;
         end
         `BHCD_STATE_RUN: begin
            if (!overLimit)
               state_next = `BHCD_STATE_IDLE;
            else if (limitCnt_reg >= LIMIT_DELAY - 1)
               state_next = `BHCD_STATE_LIMIT;
         end
         `BHCD_STATE_LIMIT: begin
            if (pwmRise)
               state_next = `BHCD_STATE_IDLE;
         end
         default: begin
            state_next = `BHCD_STATE_IDLE;
         end
      endcase
   end

   // counter clears outside the delay so each excursion is timed afresh
   always @* begin
      if (state_reg == `BHCD_STATE_RUN)
         limitCnt_next = limitCnt_reg + 8'h01;
      else
         limitCnt_next = {`BHCD_LIMIT_CNT_WIDTH{1'b0}};
      if (state_next == `BHCD_STATE_LIMIT)
         limitOff_next = 1'b1;
      else
         limitOff_next = 1'b0;
   end

   always @(posedge clock) begin
      if (rst) begin
         state_reg <= `BHCD_STATE_IDLE;
         limitCnt_reg <= {`BHCD_LIMIT_CNT_WIDTH{1'b0}};
         limitOff_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         limitCnt_reg <= limitCnt_next;
         limitOff_reg <= limitOff_next;
      end
   end

   // one detect and one recover level shared by all three supplies
   assign bootLow[2] = boot_cap_a < boot_detect_level;
   assign bootLow[1] = boot_cap_b < boot_detect_level;
   assign bootLow[0] = boot_cap_c < boot_detect_level;
   assign bootOk[2] = boot_cap_a >= boot_recover_level;
   assign bootOk[1] = boot_cap_b >= boot_recover_level;
   assign bootOk[0] = boot_cap_c >= boot_recover_level;

   // gate latches are the output flops; chop by gating command with pwm
   // one latch per phase so an undervoltage on one bootstrap leaves the others running
   bhcd_high_latch highLatchA (
      .clock(clock),
      .rst(rst),
      .command(highCmd[2] & pwmNow & ~speedOff),
      .turnOnPulse(turnOnPulse),
      .bootLow(bootLow[2]),
      .bootRecovered(bootOk[2]),
      .limitOff(limitCut),
      .gateOn(gateOn[2])
   );

   bhcd_high_latch highLatchB (
      .clock(clock),
      .rst(rst),
      .command(highCmd[1] & pwmNow & ~speedOff),
      .turnOnPulse(turnOnPulse),
      .bootLow(bootLow[1]),
      .bootRecovered(bootOk[1]),
      .limitOff(limitCut),
      .gateOn(gateOn[1])
   );

   bhcd_high_latch highLatchC (
      .clock(clock),
      .rst(rst),
      .command(highCmd[0] & pwmNow & ~speedOff),
      .turnOnPulse(turnOnPulse),
      .bootLow(bootLow[0]),
      .bootRecovered(bootOk[0]),
      .limitOff(limitCut),
      .gateOn(gateOn[0])
   );

   assign highSideA = gateOn[2];
   assign highSideB = gateOn[1];
   assign highSideC = gateOn[0];

   // low side is never chopped; table keeps it apart from the high side
   always @* begin
      lowSide_next = lowCmd & ~highCmd & {3{~speedOff}};
      if (selectHigh)
         revolution_next = (hallNow == 3'h6) | (hallNow == 3'h5) | (hallNow == 3'h3);
      else
         revolution_next = hallNow[2];
   end

   always @(posedge clock) begin
      if (rst) begin
         hall_reg <= 3'h0;
         pwm_reg <= 1'b0;
         lowSideA <= 1'b0;
         lowSideB <= 1'b0;
         lowSideC <= 1'b0;
         revolution_pulse_out <= 1'b0;
      end else begin
         hall_reg <= hallNow;
         pwm_reg <= pwmNow;
         lowSideA <= lowSide_next[2];
         lowSideB <= lowSide_next[1];
         lowSideC <= lowSide_next[0];
         revolution_pulse_out <= revolution_next;
      end
   end
endmodule // bhcd_hall_decoder

// ---- testbench/bhcd_hall_source.sv ----
// hall sensor model giving comparator samples per phase
`timescale 1ns/100ps
module bhcd_hall_source (
   input wire clock,
   input wire [2:0] hallState,
   output reg [7:0] hall_a_pos,
   output reg [7:0] hall_a_neg,
   output reg [7:0] hall_b_pos,
   output reg [7:0] hall_b_neg,
   output reg [7:0] hall_c_pos,
   output reg [7:0] hall_c_neg
);
   // low is shown as pos equal to neg, the tightest case of not above
   always @(posedge clock) begin
      hall_a_neg <= 8'h70;
      hall_b_neg <= 8'h80;
      hall_c_neg <= 8'h90;
      hall_a_pos <= 8'h70 + {7'h00, hallState[2]};
      hall_b_pos <= 8'h80 + {7'h00, hallState[1]};
      hall_c_pos <= 8'h90 + {7'h00, hallState[0]};
   end
endmodule // bhcd_hall_source

// ---- testbench/bhcd_hall_decoder_assertions.sv ----
// port checker for the hall commutation decoder
`timescale 1ns/100ps
module bhcd_checker #(
   parameter REF_WIDTH = 8,
   parameter [REF_WIDTH-1:0] SPEED_OFF = 8'h20
) (
   input wire clock,
   input wire rst,
   input wire [REF_WIDTH-1:0] hall_a_pos,
   input wire [REF_WIDTH-1:0] hall_a_neg,
   input wire [REF_WIDTH-1:0] hall_b_pos,
   input wire [REF_WIDTH-1:0] hall_b_neg,
   input wire [REF_WIDTH-1:0] hall_c_pos,
   input wire [REF_WIDTH-1:0] hall_c_neg,
   input wire pulse_count_select,
   input wire pulse_count_select_open,
   input wire [REF_WIDTH-1:0] speed_reference_in,
   input wire [REF_WIDTH-1:0] boot_cap_a,
   input wire [REF_WIDTH-1:0] boot_detect_level,
   input wire highSideA,
   input wire highSideB,
   input wire highSideC,
   input wire lowSideA,
   input wire lowSideB,
   input wire lowSideC,
   input wire revolution_pulse_out
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   wire [2:0] h = {hall_a_pos > hall_a_neg, hall_b_pos > hall_b_neg, hall_c_pos > hall_c_neg};
   wire spdOk = speed_reference_in >= SPEED_OFF;
   wire [2:0] lo = !spdOk ? 3'h0 : (h == 3'h5 || h == 3'h4) ? 3'h4 : (h == 3'h6 || h == 3'h2) ? 3'h2
      : (h == 3'h3 || h == 3'h1) ? 3'h1 : 3'h0;
   wire [2:0] hi = (h == 3'h2 || h == 3'h3) ? 3'h4 : (h == 3'h5 || h == 3'h1) ? 3'h2
      : (h == 3'h4 || h == 3'h6) ? 3'h1 : 3'h0;
   wire selHigh = pulse_count_select | pulse_count_select_open;
   wire revExp = selHigh ? (h == 3'h3 || h == 3'h5 || h == 3'h6) : h[2];
   wire [2:0] highs = {highSideA, highSideB, highSideC};
   wire [2:0] lows = {lowSideA, lowSideB, lowSideC};
   a_low_side_a: assert property (!rst |=> lowSideA == $past(lo[2])) else $error("low side A wrong");
   a_low_side_b: assert property (!rst ##1 1'b1 |-> lowSideB == $past(lo[1])) else $error("low side B wrong");
   a_low_side_c: assert property (!rst |=> lowSideC == $past(lo[0])) else $error("low side C wrong");
   a_rev_pulse: assert property (!rst |=> revolution_pulse_out == $past(revExp)) else $error("rev wrong");
   a_no_overlap: assert property ((highs & lows) == 3'h0) else $error("phase high and low both on");
   a_high_command: assert property (|highs |-> (highs & ~$past(hi)) == 3'h0) else $error("high not commanded");
   a_boot_cut: assert property ($past(boot_cap_a < boot_detect_level) |-> !highSideA) else $error("boot low on");
   a_speed_rise: assert property ((highs & ~$past(highs)) != 3'h0 |-> $past(spdOk)) else $error("rise off");
   cover property (lowSideA && highSideB);
   cover property (revolution_pulse_out && !selHigh);
   cover property (boot_cap_a < boot_detect_level ##1 lowSideB);
endmodule // bhcd_checker
bind bhcd_hall_decoder bhcd_checker #(.REF_WIDTH(REF_WIDTH), .SPEED_OFF(SPEED_OFF)) chk_u (.*);

// ---- testbench/bhcd_hall_decoder_test.sv ----
// self-checking bench for the hall commutation decoder
`timescale 1ns/100ps
module bhcd_hall_decoder_test;
   reg clock = 1'b0;
   reg rst = 1'b1;
   reg [2:0] hallState = 3'h0;
   reg pulse_count_select = 1'b1, pulse_count_select_open = 1'b0;
   reg [7:0] speed_reference_in = 8'h00;
   reg [7:0] current_sense_in = 8'h00, boot_cap_a = 8'hF0, boot_cap_b = 8'hF0, boot_cap_c = 8'hF0;
   reg [7:0] carrier_cap_pin = 8'h00;
   wire [7:0] carrier_res_pin = 8'h00, current_limit_level = 8'h80;
   wire [7:0] boot_detect_level = 8'h30, boot_recover_level = 8'h38;
   wire [7:0] hall_a_pos, hall_a_neg, hall_b_pos, hall_b_neg, hall_c_pos, hall_c_neg;
   wire highSideA, highSideB, highSideC, lowSideA, lowSideB, lowSideC, revolution_pulse_out;
   integer mismatches = 0, comparisons = 0, base;
   integer hiCnt [0:2];
   integer loCnt [0:2];
   // short limit delay keeps the over-current window inside one carrier period
   bhcd_hall_decoder #(.LIMIT_DELAY(4)) dut_u (.*);
   bhcd_hall_source model_u (.*);
   initial begin
      forever #12.5 clock = ~clock;
   end
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task drive(input [2:0] h, input [7:0] s);
      @(posedge clock);
      hallState <= h;
      speed_reference_in <= s;
      repeat (4) @(posedge clock);
   endtask
   // 68 cycles spans several carrier periods at the fastest step
   task measure;
      integer i;
      reg [2:0] hs, ls;
      for (i = 0; i < 3; i = i + 1) begin
         hiCnt[i] = 0;
         loCnt[i] = 0;
      end
      repeat (68) begin
         @(negedge clock);
         hs = {highSideC, highSideB, highSideA};
         ls = {lowSideC, lowSideB, lowSideA};
         for (i = 0; i < 3; i = i + 1) begin
            hiCnt[i] = hiCnt[i] + hs[i];
            loCnt[i] = loCnt[i] + ls[i];
         end
      end
   endtask
   // one rising edge of phase A high side per carrier period
   task count_rises(output integer n);
      reg prev;
      n = 0;
      prev = highSideA;
      repeat (144) begin
         @(negedge clock);
         if (highSideA && !prev)
            n = n + 1;
         prev = highSideA;
      end
   endtask
   // step 31 gives an 18-cycle carrier, step 16 a 32-cycle one
   task carrier_rate;
      integer fast, slow;
      drive(3'h2, 8'h80);
      count_rises(fast);
      @(posedge clock);
      carrier_cap_pin <= 8'hFF;
      repeat (40) @(posedge clock);
      count_rises(slow);
      check("carrier rate", fast > slow, 1);
      @(posedge clock);
      carrier_cap_pin <= 8'h00;
   endtask
   task truth_table;
      integer m, k, i;
      reg [2:0] lo, hi;
      for (m = 0; m < 3; m = m + 1) begin
         @(posedge clock);
         pulse_count_select <= (m == 0);
         pulse_count_select_open <= (m == 2);
         for (k = 0; k < 8; k = k + 1) begin
            lo = (k == 5 || k == 4) ? 3'h4 : (k == 6 || k == 2) ? 3'h2 : (k == 3 || k == 1) ? 3'h1 : 3'h0;
            hi = (k == 2 || k == 3) ? 3'h4 : (k == 5 || k == 1) ? 3'h2 : (k == 4 || k == 6) ? 3'h1 : 3'h0;
            drive(k[2:0], 8'hC0);
            measure;
            for (i = 0; i < 3; i = i + 1) begin
               check("low side", loCnt[2-i], lo[i] ? 68 : 0);
               check("high chop", hi[i] ? (hiCnt[2-i] > 0 && hiCnt[2-i] < 68) : hiCnt[2-i] == 0, 1);
            end
            check("revolution", revolution_pulse_out, m != 1 ? (k == 3 || k == 5 || k == 6) : k >= 4);
         end
      end
   endtask
   task duty_and_limit;
      drive(3'h2, 8'h50);
      measure;
      base = hiCnt[0];
      drive(3'h2, 8'hE0);
      measure;
      check("duty order", hiCnt[0] > base, 1);
      base = hiCnt[0];
      @(posedge clock);
      current_sense_in <= 8'hF0;
      measure;
      check("limit cut", hiCnt[0] < base, 1);
      @(posedge clock);
      current_sense_in <= 8'h00;
   endtask
   task speed_off;
      drive(3'h5, 8'h1F);
      measure;
      check("speed off", hiCnt[0] + hiCnt[1] + hiCnt[2] + loCnt[0] + loCnt[1] + loCnt[2], 0);
      drive(3'h5, 8'h20);
      measure;
      check("speed on", loCnt[0], 68);
   endtask
   task boot_lockout;
      @(posedge clock);
      boot_cap_a <= 8'h20;
      drive(3'h2, 8'hC0);
      measure;
      check("boot low", hiCnt[0], 0);
      check("low unaffected", loCnt[1], 68);
      @(posedge clock);
      boot_cap_a <= 8'h34;
      measure;
      check("boot hysteresis", hiCnt[0], 0);
      @(posedge clock);
      boot_cap_a <= 8'h38;
      measure;
      check("boot recovered", hiCnt[0] > 0, 1);
   endtask
   task summarize;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #250000;
      mismatches = mismatches + 1;
      summarize;
   end
   initial begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      truth_table;
      duty_and_limit;
      speed_off;
      carrier_rate;
      boot_lockout;
      summarize;
   end
endmodule // bhcd_hall_decoder_test
